// *** rtl/edl_defines.svh ***
// Constants for the event-linked DMA channel engine
`ifndef EDL_DEFINES_SVH
`define EDL_DEFINES_SVH
`define EDL_NCH            16
`define EDL_NSET           32
`define EDL_RR_ONE         4'h1
`define EDL_TOP_WORD_LSB   8'ha0
`define EDL_WORDS          3'h6
`define EDL_REG_EVENT_EN   9'h100
`define EDL_REG_CHAIN_EN   9'h101
`define EDL_REG_EVENT_SET  9'h102
`define EDL_REG_EVENT_PEND 9'h103
`define EDL_REG_COMPLETE   9'h104
`define EDL_REG_STATUS     9'h105
`define EDL_REG_SEL        8
`define EDL_OPT_SYNC       0
`define EDL_OPT_LINK       1
`define EDL_OPT_SRC2D      2
`define EDL_OPT_DST2D      3
`define EDL_OPT_SRCM       5:4
`define EDL_OPT_DSTM       7:6
`define EDL_OPT_SIZE       9:8
`define EDL_OPT_PRIO       10
`define EDL_OPT_IRQEN      11
`define EDL_OPT_REPORT     19:16
`define EDL_LINK_SET       9:5
`define EDL_MODE_FIXED     2'h0
`define EDL_MODE_INC       2'h1
`define EDL_MODE_DEC       2'h2
`define EDL_MODE_IDX       2'h3
`define EDL_SIZE_WORD      2'h0
`define EDL_SIZE_HALF      2'h1
`define EDL_SIZE_BYTE      2'h2
`define EDL_BYTES_WORD     32'h4
`define EDL_BYTES_HALF     32'h2
`define EDL_BYTES_BYTE     32'h1
`define EDL_CNT_ONE        16'h1
`define EDL_CH_SER_TX      12
`define EDL_CH_SER_RX      13
`define EDL_CH_EXT4        4
`endif

// *** rtl/edl_event_route.sv ***
// Routes and synchronises peripheral event pins onto channel event pulses
`timescale 1ns/10ps
`default_nettype none
`include "edl_defines.svh"
module edl_event_route (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic [15:0] event_pins,
	input  wire logic        serial_rx_event,
	input  wire logic        serial_tx_event,
	input  wire logic        ext_irq_four,
	output logic      [15:0] ev_pulse
);
	genvar i;
	generate
		for (i = 0; i < `EDL_NCH; i++) begin : g_ch
			logic raw;
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic pulse_q;
			// Dedicated peripheral events take their fixed channels
			if (i == `EDL_CH_SER_RX) begin : g_rx
				assign raw = serial_rx_event;
			end else if (i == `EDL_CH_SER_TX) begin : g_tx
				assign raw = serial_tx_event;
			end else if (i == `EDL_CH_EXT4) begin : g_ext
				assign raw = ext_irq_four;
			end else begin : g_pin
				assign raw = event_pins[i];
			end
			always_ff @(posedge clock) begin
				if (rst) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
					pulse_q <= 1'b0;
				end else begin
					s1_q <= raw;
					s2_q <= s1_q;
					s3_q <= s2_q;
					pulse_q <= s2_q & ~s3_q;
				end
			end
			assign ev_pulse[i] = pulse_q;
		end
	endgenerate
endmodule : edl_event_route
`default_nettype wire

// *** rtl/edl_memory_a_ram.sv ***
// Parameter memory: word port for software, whole-set port for the engine
`timescale 1ns/10ps
`default_nettype none
`include "edl_defines.svh"
module edl_memory_a_ram (
	input  wire logic              clock,
	input  wire logic [7:0]        bus_addr,
	input  wire logic              bus_we,
	input  wire logic [31:0]       bus_wdata,
	output logic      [31:0]       bus_rdata,
	input  wire logic [4:0]        eng_idx,
	input  wire logic              eng_we,
	input  wire edl_pkg::edl_set_t eng_wdata,
	output edl_pkg::edl_set_t      eng_rdata
);
	logic [191:0] mem [`EDL_NSET];
	logic [7:0]   lsb;
	logic         word_ok;

	assign lsb = `EDL_TOP_WORD_LSB - {bus_addr[2:0], 5'h0};
	assign word_ok = bus_addr[2:0] < `EDL_WORDS;
	assign bus_rdata = word_ok ? mem[bus_addr[7:3]][lsb +: 32] : 32'h0;

	// Engine writes win; the bus slave stalls while they happen
	always_ff @(posedge clock) begin
		if (eng_we) begin
			mem[eng_idx] <= eng_wdata;
		end else if (bus_we && word_ok) begin
			mem[bus_addr[7:3]][lsb +: 32] <= bus_wdata;
		end
	end

	always_ff @(posedge clock) begin
		eng_rdata <= mem[eng_idx];
	end
endmodule : edl_memory_a_ram
`default_nettype wire

// *** rtl/edl_pkg.sv ***
// Types shared by the event-linked DMA channel engine
package edl_pkg;
	typedef struct packed {
		logic [31:0] opt;
		logic [31:0] src;
		logic [15:0] fcnt;
		logic [15:0] ecnt;
		logic [31:0] dst;
		logic [15:0] fidx;
		logic [15:0] eidx;
		logic [15:0] rld;
		logic [15:0] link;
	} edl_set_t;

	typedef struct packed {
		logic [31:0] src;
		logic [31:0] dst;
		logic [1:0]  size;
		logic        high_prio;
	} edl_xfer_t;

	typedef enum logic [2:0] {
		S_IDLE,
		S_LOAD,
		S_MOVE,
		S_SAVE,
		S_FIN,
		S_LINK
	} edl_state_t;
endpackage : edl_pkg

// *** rtl/edl_top.sv ***
// Event-synchronised DMA channel engine with linking and completion flags
// Notes on behaviour
// - One channel per event, all independent
// - Events count only when enabled or triggered
// - Update mode 00 holds address fixed
// - Update mode 01 steps by element size
// - Update mode 11 uses element/frame index
// - Size code 10 selects byte elements
// - High priority requests go on queue one
// - Sync select picks array or frame per event
// - 1-D, sync clear: one element per event
// - 2-D arrays advance by array index (update mode 10 ignores it, only stepping back by element size)
// - Exhausted counts reload set from link address
// - Element count reloads when reaching zero
// - Completion sets report bit, raises interrupt
// - Completion pending bits stay until software clears
// - Pending register readable at any time
// - Serial receive to 13, transmit to 12
// - External interrupt four drives channel 4
//
// Implementation choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "edl_defines.svh"
module edl_top (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic [8:0]   avs_address,
	input  wire logic         avs_read,
	input  wire logic         avs_write,
	input  wire logic [31:0]  avs_writedata,
	output logic      [31:0]  avs_readdata,
	output logic              avs_waitrequest,
	input  wire logic [15:0]  event_pins,
	input  wire logic         serial_rx_event,
	input  wire logic         serial_tx_event,
	input  wire logic         ext_irq_four,
	output edl_pkg::edl_xfer_t xfer_req,
	output logic              xfer_valid,
	input  wire logic         xfer_ready,
	output logic      [15:0]  complete_pending,
	output logic              complete_irq
);
	edl_pkg::edl_state_t state_q;
	edl_pkg::edl_set_t   w_q;
	edl_pkg::edl_set_t   ram_set;
	logic [15:0] ev_pulse;
	logic [15:0] event_en_q;
	logic [15:0] chain_en_q;
	logic [15:0] pend_q;
	logic [15:0] pend_set;
	logic [15:0] pend_clr;
	logic [15:0] cpend_q;
	logic [15:0] cpend_set;
	logic [15:0] cpend_clr;
	logic [15:0] sw_set;
	logic [15:0] report_hot;
	logic [31:0] rd_d;
	logic [31:0] rd_q;
	logic [31:0] ram_rdata;
	logic [31:0] sstart_q;
	logic [31:0] dstart_q;
	logic [31:0] src_n;
	logic [31:0] dst_n;
	logic [3:0]  rr_q;
	logic [3:0]  ch_q;
	logic [4:0]  eng_idx;
	logic        eng_we;
	logic        ack_q;
	logic        req;
	logic        wr_fire;
	logic        irq_q;
	logic        last_e;
	logic        last_f;
	logic        two_d;
	logic        fs;
	logic        stop;
	logic        step;
	logic        fin;

	function automatic logic [31:0] elem_bytes(input logic [1:0] code);
		case (code)
			`EDL_SIZE_HALF: return `EDL_BYTES_HALF;
			`EDL_SIZE_BYTE: return `EDL_BYTES_BYTE;
			default:        return `EDL_BYTES_WORD;
		endcase
	endfunction : elem_bytes

	function automatic logic [31:0] next_addr(input logic [31:0] addr, input logic [31:0] start,
			input logic [1:0] mode, input logic arr2d, input logic lastel,
			input logic [31:0] sz, input logic [15:0] eidx, input logic [15:0] fidx);
		logic [31:0] ei;
		logic [31:0] fi;
		ei = {{16{eidx[15]}}, eidx};
		fi = {{16{fidx[15]}}, fidx};
		case (mode)
			`EDL_MODE_FIXED: return addr;
			`EDL_MODE_INC:   return (arr2d && lastel) ? start + fi : addr + sz;
			`EDL_MODE_DEC:   return addr - sz;
			default:         return lastel ? addr + fi : addr + ei;
		endcase
	endfunction : next_addr

	edl_event_route u_route (
		.clock           (clock),
		.rst             (rst),
		.event_pins      (event_pins),
		.serial_rx_event (serial_rx_event),
		.serial_tx_event (serial_tx_event),
		.ext_irq_four    (ext_irq_four),
		.ev_pulse        (ev_pulse)
	);

	edl_memory_a_ram u_ram (
		.clock     (clock),
		.bus_addr  (avs_address[7:0]),
		.bus_we    (wr_fire && !avs_address[`EDL_REG_SEL]),
		.bus_wdata (avs_writedata),
		.bus_rdata (ram_rdata),
		.eng_idx   (eng_idx),
		.eng_we    (eng_we),
		.eng_wdata ((state_q == edl_pkg::S_LINK) ? ram_set : w_q),
		.eng_rdata (ram_set)
	);

	// Bus slave: one wait state, longer while the engine writes the set memory
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & (~ack_q | eng_we);
	assign wr_fire = avs_write & ~avs_waitrequest;
	assign avs_readdata = rd_q;

	always_comb begin
		case (avs_address)
			`EDL_REG_EVENT_EN:   rd_d = {16'h0, event_en_q};
			`EDL_REG_CHAIN_EN:   rd_d = {16'h0, chain_en_q};
			`EDL_REG_EVENT_PEND: rd_d = {16'h0, pend_q};
			`EDL_REG_COMPLETE:   rd_d = {16'h0, cpend_q};
			`EDL_REG_STATUS:     rd_d = {27'h0, state_q != edl_pkg::S_IDLE, ch_q};
			default:             rd_d = avs_address[`EDL_REG_SEL] ? 32'h0 : ram_rdata;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ack_q <= 1'b0;
			rd_q <= 32'h0;
		end else begin
			ack_q <= req & ~(ack_q & ~eng_we);
			rd_q <= rd_d;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			event_en_q <= 16'h0;
			chain_en_q <= 16'h0;
		end else if (wr_fire && avs_address == `EDL_REG_EVENT_EN) begin
			event_en_q <= avs_writedata[15:0];
		end else if (wr_fire && avs_address == `EDL_REG_CHAIN_EN) begin
			chain_en_q <= avs_writedata[15:0];
		end
	end

	// Event capture: a new event beats the clear of its own pending bit
	assign sw_set = (wr_fire && avs_address == `EDL_REG_EVENT_SET) ? avs_writedata[15:0] : 16'h0;
	assign report_hot = 16'h1 << w_q.opt[`EDL_OPT_REPORT];
	assign fin = state_q == edl_pkg::S_FIN;
	assign pend_set = (ev_pulse & event_en_q) | sw_set
		| ((fin && w_q.opt[`EDL_OPT_IRQEN]) ? report_hot & chain_en_q : 16'h0);
	assign pend_clr = (state_q == edl_pkg::S_IDLE && pend_q[rr_q]) ? 16'h1 << rr_q : 16'h0;

	always_ff @(posedge clock) begin
		if (rst) begin
			pend_q <= 16'h0;
		end else begin
			pend_q <= (pend_q & ~pend_clr) | pend_set;
		end
	end

	// Completion flags: set on completion, cleared only by a write of ones
	assign cpend_set = (fin && w_q.opt[`EDL_OPT_IRQEN]) ? report_hot : 16'h0;
	assign cpend_clr = (wr_fire && avs_address == `EDL_REG_COMPLETE) ? avs_writedata[15:0] : 16'h0;
	assign complete_pending = cpend_q;
	assign complete_irq = irq_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			cpend_q <= 16'h0;
			irq_q <= 1'b0;
		end else begin
			cpend_q <= (cpend_q & ~cpend_clr) | cpend_set;
			irq_q <= fin & w_q.opt[`EDL_OPT_IRQEN];
		end
	end

	// Element stepping
	assign last_e = w_q.ecnt == `EDL_CNT_ONE;
	assign last_f = w_q.fcnt == 16'h0;
	assign two_d = w_q.opt[`EDL_OPT_SRC2D] | w_q.opt[`EDL_OPT_DST2D];
	assign fs = w_q.opt[`EDL_OPT_SYNC];
	assign step = (state_q == edl_pkg::S_MOVE) && xfer_ready;
	// Per event: element, array or frame, or the whole block
	assign stop = (last_e && last_f) || (last_e ? !(fs && two_d) : !(fs || two_d));
	assign src_n = next_addr(w_q.src, sstart_q, w_q.opt[`EDL_OPT_SRCM], w_q.opt[`EDL_OPT_SRC2D],
		last_e, elem_bytes(w_q.opt[`EDL_OPT_SIZE]), w_q.eidx, w_q.fidx);
	assign dst_n = next_addr(w_q.dst, dstart_q, w_q.opt[`EDL_OPT_DSTM], w_q.opt[`EDL_OPT_DST2D],
		last_e, elem_bytes(w_q.opt[`EDL_OPT_SIZE]), w_q.eidx, w_q.fidx);

	assign xfer_valid = state_q == edl_pkg::S_MOVE;
	assign xfer_req.src = w_q.src;
	assign xfer_req.dst = w_q.dst;
	assign xfer_req.size = w_q.opt[`EDL_OPT_SIZE];
	assign xfer_req.high_prio = w_q.opt[`EDL_OPT_PRIO];

	always_ff @(posedge clock) begin
		if (rst) begin
			w_q <= '0;
			sstart_q <= 32'h0;
			dstart_q <= 32'h0;
		end else if (state_q == edl_pkg::S_LOAD) begin
			w_q <= ram_set;
			sstart_q <= ram_set.src;
			dstart_q <= ram_set.dst;
		end else if (step) begin
			w_q.src <= src_n;
			w_q.dst <= dst_n;
			if (last_e) begin
				w_q.ecnt <= last_f ? 16'h0 : w_q.rld;
				sstart_q <= src_n;
				dstart_q <= dst_n;
				if (!last_f) begin
					w_q.fcnt <= w_q.fcnt - `EDL_CNT_ONE;
				end
			end else begin
				w_q.ecnt <= w_q.ecnt - `EDL_CNT_ONE;
			end
		end
	end

	// Set memory port for the engine
	always_comb begin
		case (state_q)
			edl_pkg::S_IDLE: eng_idx = {1'b0, rr_q};
			edl_pkg::S_FIN:  eng_idx = w_q.opt[`EDL_OPT_LINK] ? w_q.link[`EDL_LINK_SET]
				: {1'b0, ch_q};
			default:         eng_idx = {1'b0, ch_q};
		endcase
	end
	assign eng_we = (state_q == edl_pkg::S_SAVE) || (state_q == edl_pkg::S_LINK)
		|| (fin && !w_q.opt[`EDL_OPT_LINK]);

	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= edl_pkg::S_IDLE;
			rr_q <= 4'h0;
			ch_q <= 4'h0;
		end else begin
			case (state_q)
				edl_pkg::S_IDLE: begin
					if (pend_q[rr_q]) begin
						ch_q <= rr_q;
						state_q <= edl_pkg::S_LOAD;
					end
					rr_q <= rr_q + `EDL_RR_ONE;
				end
				edl_pkg::S_LOAD: begin
					state_q <= (ram_set.ecnt == 16'h0) ? edl_pkg::S_IDLE : edl_pkg::S_MOVE;
				end
				edl_pkg::S_MOVE: begin
					if (xfer_ready && stop) begin
						state_q <= (last_e && last_f) ? edl_pkg::S_FIN : edl_pkg::S_SAVE;
					end
				end
				edl_pkg::S_FIN: begin
					state_q <= w_q.opt[`EDL_OPT_LINK] ? edl_pkg::S_LINK : edl_pkg::S_IDLE;
				end
				// Reload ends before any other event is taken
				edl_pkg::S_LINK: state_q <= edl_pkg::S_IDLE;
				default: state_q <= edl_pkg::S_IDLE;
			endcase
		end
	end

	a_fixed_src: assert property (@(posedge clock) disable iff (rst)
		step && w_q.opt[`EDL_OPT_SRCM] == `EDL_MODE_FIXED |=> w_q.src == $past(w_q.src))
		else $error("fixed source address moved");
	a_linear_step: assert property (@(posedge clock) disable iff (rst)
		step && w_q.opt[`EDL_OPT_DSTM] == `EDL_MODE_INC && !w_q.opt[`EDL_OPT_DST2D]
		|=> w_q.dst == $past(w_q.dst) + elem_bytes($past(w_q.opt[`EDL_OPT_SIZE])))
		else $error("linear step wrong");
	a_byte_step: assert property (@(posedge clock) disable iff (rst)
		step && w_q.opt[`EDL_OPT_SIZE] == `EDL_SIZE_BYTE && w_q.opt[`EDL_OPT_SRCM] == `EDL_MODE_INC
		&& !w_q.opt[`EDL_OPT_SRC2D] |=> w_q.src == $past(w_q.src) + 32'h1)
		else $error("byte element did not step by one");
	a_index_step: assert property (@(posedge clock) disable iff (rst)
		step && w_q.opt[`EDL_OPT_SRCM] == `EDL_MODE_IDX && !last_e
		|=> w_q.src == $past(w_q.src) + {{16{$past(w_q.eidx[15])}}, $past(w_q.eidx)})
		else $error("element index not applied");
	a_one_element: assert property (@(posedge clock) disable iff (rst)
		step && !fs && !two_d && !(last_e && last_f) |=> state_q == edl_pkg::S_SAVE
		##1 state_q == edl_pkg::S_IDLE)
		else $error("more than one element per event");
	a_count_reload: assert property (@(posedge clock) disable iff (rst)
		step && last_e && !last_f |=> w_q.ecnt == $past(w_q.rld)
		&& w_q.fcnt == $past(w_q.fcnt) - `EDL_CNT_ONE)
		else $error("element count not reloaded");
	a_queue_select: assert property (@(posedge clock) disable iff (rst)
		xfer_valid |-> xfer_req.high_prio == w_q.opt[`EDL_OPT_PRIO])
		else $error("queue select wrong");
	a_complete_flag: assert property (@(posedge clock) disable iff (rst)
		fin && w_q.opt[`EDL_OPT_IRQEN] |=> complete_irq && (cpend_q & $past(report_hot)) != 16'h0)
		else $error("completion not flagged");
	a_pending_sticky: assert property (@(posedge clock) disable iff (rst)
		1'b1 |=> (cpend_q & $past(cpend_q & ~cpend_clr)) == $past(cpend_q & ~cpend_clr))
		else $error("pending bit dropped without clear");
	a_event_gate: assert property (@(posedge clock) disable iff (rst)
		1'b1 |=> (pend_q & ~$past(pend_q) & ~$past(pend_set)) == 16'h0
		&& ($past(ev_pulse & ~event_en_q & ~pend_q & ~sw_set & ~chain_en_q) & pend_q) == 16'h0)
		else $error("disabled event was taken");
	a_link_reload: assert property (@(posedge clock) disable iff (rst)
		fin && w_q.opt[`EDL_OPT_LINK] |=> state_q == edl_pkg::S_LINK && eng_we
		&& eng_idx == {1'b0, ch_q} ##1 state_q == edl_pkg::S_IDLE)
		else $error("link reload missing");
endmodule : edl_top
`default_nettype wire

// *** verification/edl_mem_model.sv ***
// Memory-side partner model: takes element requests, optionally stalling
`timescale 1ns/10ps
`default_nettype none
module edl_mem_model (
	input  wire logic               clock,
	input  wire logic               rst,
	input  wire logic               slow,
	input  wire edl_pkg::edl_xfer_t xfer_req,
	input  wire logic               xfer_valid,
	output logic                    xfer_ready
);
	edl_pkg::edl_xfer_t got[$];

	// Stalls every other cycle when slow, so offered requests must hold
	always_ff @(posedge clock) begin
		if (rst) begin
			xfer_ready <= 1'b0;
		end else begin
			xfer_ready <= slow ? ~xfer_ready : 1'b1;
		end
	end

	// Logs each element at the edge it is taken
	always @(posedge clock) begin
		if (!rst && xfer_valid === 1'b1 && xfer_ready === 1'b1) begin
			got.push_back(xfer_req);
		end
	end
endmodule : edl_mem_model
`default_nettype wire

// *** verification/edl_top_tb_top.sv ***
// Self-checking bench for the event-linked DMA channel engine
`timescale 1ns/10ps
`default_nettype none
module edl_top_tb_top;
	logic               clock = 1'b0;
	logic               rst = 1'b1;
	logic        [8:0]  avs_address = 9'h000;
	logic               avs_read = 1'b0;
	logic               avs_write = 1'b0;
	logic        [31:0] avs_writedata = 32'h0;
	logic        [31:0] avs_readdata;
	logic               avs_waitrequest;
	logic        [18:0] pins_q = 19'h0;
	logic               slow = 1'b0;
	edl_pkg::edl_xfer_t xfer_req;
	logic               xfer_valid;
	logic               xfer_ready;
	logic        [15:0] complete_pending;
	logic               complete_irq;
	logic        [31:0] rd;
	int                 err_count = 0;
	int                 checks_done = 0;
	int                 irq_cnt = 0;
	int                 cyc = 0;

	always #25 clock = ~clock;

	edl_top dut_u (
		.clock           (clock),
		.rst             (rst),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.event_pins      (pins_q[15:0]),
		.serial_tx_event (pins_q[16]),
		.serial_rx_event (pins_q[17]),
		.ext_irq_four    (pins_q[18]),
		.xfer_req        (xfer_req),
		.xfer_valid      (xfer_valid),
		.xfer_ready      (xfer_ready),
		.complete_pending(complete_pending),
		.complete_irq    (complete_irq)
	);

	edl_mem_model mem_u (
		.clock     (clock),
		.rst       (rst),
		.slow      (slow),
		.xfer_req  (xfer_req),
		.xfer_valid(xfer_valid),
		.xfer_ready(xfer_ready)
	);

	always @(posedge clock) begin
		if (complete_irq === 1'b1) begin
			irq_cnt++;
		end
		cyc++;
		if (cyc == 6000) begin
			err_count++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Request held until the rising edge at which waitrequest is sampled low
	task automatic bus(input logic we, input logic [8:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_write <= we;
		avs_read <= ~we;
		avs_writedata <= d;
		do begin
			@(posedge clock);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clock);
	endtask : bus

	task automatic rdchk(input logic [8:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdchk

	task automatic set_wr(input logic [4:0] s, input logic [31:0] w0, input logic [31:0] w1,
			input logic [31:0] w2, input logic [31:0] w3, input logic [31:0] w4,
			input logic [31:0] w5);
		logic [31:0] w[6];
		w = '{w0, w1, w2, w3, w4, w5};
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, {1'b0, s, i[2:0]}, w[i]);
		end
	endtask : set_wr

	task automatic fire(input int b);
		pins_q[b] <= 1'b1;
		repeat (2) @(posedge clock);
		pins_q[b] <= 1'b0;
		@(posedge clock);
	endtask : fire

	task automatic wait_el(input int n);
		int k;
		k = 0;
		while (mem_u.got.size() < n && k < 200) begin
			@(posedge clock);
			k++;
		end
		chk(mem_u.got.size(), n);
	endtask : wait_el

	task automatic el(input int i, input logic [31:0] s, input logic [31:0] d, input logic [2:0] sp);
		chk(mem_u.got[i].src, s);
		chk(mem_u.got[i].dst, d);
		chk({29'h0, mem_u.got[i].size, mem_u.got[i].high_prio}, {29'h0, sp});
	endtask : el

	task automatic t_regs();
		chk({16'h0, complete_pending}, 32'h0);
		rdchk(9'h100, 32'h0);
		rdchk(9'h104, 32'h0);
		bus(1'b1, 9'h1ff, 32'hffffffff);
		rdchk(9'h1ff, 32'h0);
		bus(1'b1, 9'h100, 32'h00002010);
		rdchk(9'h100, 32'h00002010);
		bus(1'b1, 9'h101, 32'h00000004);
		rdchk(9'h101, 32'h00000004);
		$display("test regs done");
	endtask : t_regs

	// Receive channel, element sync, two frames, linked to a set that links to itself
	task automatic t_link();
		mem_u.got.delete();
		set_wr(5'h0d, 32'h000d0e42, 32'h1000, 32'h00010002, 32'h2000, 32'h0, 32'h00020280);
		set_wr(5'h14, 32'h000d0e42, 32'h3000, 32'h00010002, 32'h4000, 32'h0, 32'h00020280);
		for (int k = 0; k < 4; k++) begin
			fire(17);
			wait_el(k + 1);
			el(k, 32'h1000, 32'h2000 + k, 3'h5);
			if (k == 1) begin
				chk(complete_pending[13], 1'b0);
			end
		end
		repeat (8) @(posedge clock);
		chk(complete_pending[13], 1'b1);
		chk(irq_cnt, 1);
		rdchk(9'h104, 32'h2000);
		rdchk(9'h069, 32'h3000);
		fire(17);
		wait_el(5);
		el(4, 32'h3000, 32'h4000, 3'h5);
		rdchk(9'h104, 32'h2000);
		bus(1'b1, 9'h104, 32'h2000);
		rdchk(9'h104, 32'h0);
		$display("test link done");
	endtask : t_link

	// External interrupt four: 2-D destination, one array per event
	task automatic t_array();
		mem_u.got.delete();
		set_wr(5'h04, 32'h00040148, 32'h5000, 32'h00010002, 32'h6000, 32'h05000000, 32'h20000);
		fire(18);
		wait_el(2);
		repeat (6) @(posedge clock);
		chk(mem_u.got.size(), 2);
		el(0, 32'h5000, 32'h6000, 3'h2);
		el(1, 32'h5000, 32'h6002, 3'h2);
		fire(18);
		wait_el(4);
		el(2, 32'h5000, 32'h6500, 3'h2);
		el(3, 32'h5000, 32'h6502, 3'h2);
		repeat (8) @(posedge clock);
		chk(complete_pending[4], 1'b0);
		chk(irq_cnt, 1);
		$display("test array done");
	endtask : t_array

	// Disabled pin ignored; software trigger moves a whole frame with indexed source
	task automatic t_trig();
		mem_u.got.delete();
		slow <= 1'b1;
		set_wr(5'h02, 32'h00020831, 32'h7000, 32'h3, 32'h8000, 32'h8, 32'h0);
		fire(3);
		repeat (10) @(posedge clock);
		chk(mem_u.got.size(), 0);
		bus(1'b1, 9'h102, 32'h4);
		wait_el(3);
		for (int k = 0; k < 3; k++) begin
			el(k, 32'h7000 + 8 * k, 32'h8000, 3'h0);
		end
		repeat (8) @(posedge clock);
		chk(complete_pending[2], 1'b1);
		chk(irq_cnt, 2);
		// Chained completion re-triggers channel 2 with spent counts: consumed, nothing moved
		repeat (24) @(posedge clock);
		rdchk(9'h103, 32'h0);
		rdchk(9'h105, 32'h00000002);
		chk(mem_u.got.size(), 3);
		slow <= 1'b0;
		$display("test trig done");
	endtask : t_trig

	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		t_regs();
		t_link();
		t_array();
		t_trig();
		summarize();
	end
endmodule : edl_top_tb_top
`default_nettype wire
